// >>> logic/ddrp_pkg.sv
// ddrp_pkg: constants and types for the link pair.
// assumes: both ends and the link interface import it.
package ddrp_pkg;
    // =========================================================
    // link commands and mode-register fields
    typedef enum logic [2:0] {
        DDRP_NOP = 3'h0,
        DDRP_MRS = 3'h1,
        DDRP_ACT = 3'h2,
        DDRP_PRE = 3'h3,
        DDRP_RD = 3'h4,
        DDRP_WR = 3'h5,
        DDRP_REF = 3'h6
    } ddrp_cmd_t;
    localparam logic [2:0] MR_PATTERN = 3'h3;
    localparam logic [2:0] MR_PREAMBLE = 3'h4;
    localparam int MR3_EN_BIT = 2;
    localparam int MR4_TRAIN_BIT = 10;
    localparam int MR4_RDPRE_BIT = 11;
    localparam int MR4_WRPRE_BIT = 12;
    localparam int AP_BIT = 10;
    // =========================================================
    // timing, in link clocks; CK_HALF is in aclk cycles and the strobe drive-out margin is in ns
    localparam int CK_HALF = 8;
    localparam int CL_NCK = 11;
    localparam int WL_NCK = 9;
    localparam int TMOD_NCK = 24;
    localparam int STROBE_DRIVE_OUT_DELAY_MARGIN_NS = 9;
    localparam int TRP_NCK = 12;
    localparam int TRAS_NCK = 28;
    localparam int TRCD_NCK = 12;
    localparam int PATTERN_WRITE_RECOVERY_TIME_NCK = 8;
    localparam int PATTERN_MODE_EXIT_DELAY_NCK = 1;
    localparam int TWTR_NCK = 4;
    localparam int TRFC_NCK = 40;
    // =========================================================
    // controller registers (axi4-lite byte offsets)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ddrp_pkg

// >>> logic/ddrp_link_if.sv
// ddrp_link_if: link between controller and device.
// assumes: each end drives its own pin copies with enables.
`timescale 1ns/1ps
`default_nettype none
interface ddrp_link_if;
    import ddrp_pkg::*;
    logic ck;
    ddrp_cmd_t cmd;
    logic bg;
    logic [1:0] ba;
    logic [14:0] addr;
    logic [7:0] dq_c_o, dq_d_o, dq;
    logic dq_c_oe, dq_d_oe;
    logic dqs_c_o, dqsn_c_o, dqs_c_oe;
    logic dqs_d_o, dqsn_d_o, dqs_d_oe;
    logic dqs, dqs_n;
    // =========================================================
    // wire resolution, idle bus floats high
    assign dq = dq_d_oe ? dq_d_o : (dq_c_oe ? dq_c_o : 8'hff);
    assign dqs = dqs_d_oe ? dqs_d_o : (dqs_c_oe ? dqs_c_o : 1'b1);
    assign dqs_n = dqs_d_oe ? dqsn_d_o : (dqs_c_oe ? dqsn_c_o : 1'b1);
    modport ctl (
        output ck, cmd, bg, ba, addr,
        output dq_c_o, dq_c_oe, dqs_c_o, dqsn_c_o, dqs_c_oe,
        input dq, dqs, dqs_n
    );
    modport dev (
        input ck, cmd, bg, ba, addr, dq, dqs, dqs_n,
        output dq_d_o, dq_d_oe, dqs_d_o, dqsn_d_o, dqs_d_oe
    );
endinterface : ddrp_link_if
`default_nettype wire

// >>> logic/ddrp_ctl.sv
// ddrp_ctl: controller end, axi4-lite registers to link commands.
// assumes: software issues one command at a time.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ddrp_ctl #(
    parameter int CKH = ddrp_pkg::CK_HALF,
    parameter int RL = ddrp_pkg::CL_NCK,
    parameter int WL = ddrp_pkg::WL_NCK,
    parameter bit WL_SET1 = 1'b1,
    parameter bit SPEED_2T_OK = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // link
    ddrp_link_if.ctl link
);
    import ddrp_pkg::*;
    typedef struct packed {
        logic [7:0] div;
        logic ck;
        logic awready, wready, bvalid, aw_got, w_got, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [7:0] aw_addr;
        logic [31:0] w_data, rdata;
        logic [5:0] cmd_r;
        logic [14:0] addr_r;
        logic [7:0] wdata_r;
        logic go, eng, is_wr, multi_purpose_pattern_store, wr2t;
        logic [6:0] h;
        logic [6:0] gap;
        logic [1:0] dq_s;
        logic [7:0] rbyte;
        ddrp_cmd_t l_cmd;
        logic [2:0] l_bank;
        logic [14:0] l_addr;
        logic [7:0] dq_o;
        logic dq_oe, dqs_o, dqsn_o, dqs_oe;
    } ddrp_ctl_st_t;
    ddrp_ctl_st_t s, n;
    logic tog, busy;
    logic [6:0] wl2, pre2, k;
    assign tog = (s.div == 8'(CKH - 1));
    assign busy = s.go | s.eng | (s.gap != 7'h0);
    assign wl2 = 7'(2 * WL) + ((s.wr2t && WL_SET1) ? 7'h4 : 7'h0);
    assign pre2 = s.wr2t ? 7'h4 : 7'h2;
    assign k = n.h - wl2;

    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] v, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            if (st[i]) o[8*i +: 8] = v[8*i +: 8];
        end
        return o;
    endfunction : merge

    always_comb begin
        n = s;
        n.dq_s = {s.dq_s[0], link.dq[0]};
        n.div = tog ? 8'h0 : s.div + 8'h1;
        if (tog) n.ck = ~s.ck;
        // =====================================================
        // axi write channel
        if (awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.w_data = merge(32'h0, wdata, wstrb);
        end
        if (s.bvalid && bready) n.bvalid = 1'b0;
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            unique case (s.aw_addr)
                REG_CMD: if (!busy) begin
                    n.cmd_r = s.w_data[5:0];
                    n.go = 1'b1;
                end
                REG_ADDR: n.addr_r = s.w_data[14:0];
                REG_WDATA: n.wdata_r = s.w_data[7:0];
                REG_STATUS: ;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        // =====================================================
        // axi read channel
        if (s.rvalid && rready) n.rvalid = 1'b0;
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            unique case (araddr)
                REG_CMD: n.rdata = {26'h0, s.cmd_r};
                REG_ADDR: n.rdata = {17'h0, s.addr_r};
                REG_WDATA: n.rdata = {24'h0, s.wdata_r};
                REG_STATUS: n.rdata = {16'h0, s.rbyte, 5'h0, s.wr2t,
                    s.multi_purpose_pattern_store, busy};
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;
        // =====================================================
        // command launch on the falling link edge
        if (tog && !s.ck && s.gap != 7'h0) n.gap = s.gap - 7'h1;
        if (tog && s.ck) begin
            n.l_cmd = DDRP_NOP;
            if (s.go && s.gap == 7'h0 && !s.eng) begin
                n.go = 1'b0;
                n.l_cmd = ddrp_cmd_t'(s.cmd_r[2:0]);
                n.l_bank = s.cmd_r[5:3];
                n.l_addr = s.addr_r;
                n.h = 7'h7f;
                unique case (ddrp_cmd_t'(s.cmd_r[2:0]))
                    DDRP_MRS: begin
                        n.gap = 7'(TMOD_NCK);
                        if (s.cmd_r[5:3] == MR_PATTERN) begin
                            n.multi_purpose_pattern_store = s.addr_r[MR3_EN_BIT];
                            n.l_addr[1:0] = 2'h0;
                        end
                        if (s.cmd_r[5:3] == MR_PREAMBLE) begin
                            n.l_addr[MR4_WRPRE_BIT] =
                                s.addr_r[MR4_WRPRE_BIT] & SPEED_2T_OK;
                            n.l_addr[MR4_RDPRE_BIT] =
                                s.addr_r[MR4_RDPRE_BIT] & SPEED_2T_OK;
                            n.l_addr[MR4_TRAIN_BIT] =
                                s.addr_r[MR4_TRAIN_BIT] & s.multi_purpose_pattern_store;
                            n.wr2t = s.addr_r[MR4_WRPRE_BIT] & SPEED_2T_OK;
                        end
                    end
                    DDRP_PRE: n.gap = 7'(TRP_NCK);
                    DDRP_ACT: n.gap = 7'(TRCD_NCK);
                    DDRP_REF: n.gap = 7'(TRFC_NCK); // plain 1x
                    DDRP_RD: n.eng = 1'b1;
                    DDRP_WR: if (s.multi_purpose_pattern_store) begin
                        // recovery then exit margin
                        n.gap = 7'(PATTERN_WRITE_RECOVERY_TIME_NCK + PATTERN_MODE_EXIT_DELAY_NCK);
                    end else begin
                        n.eng = 1'b1;
                    end
                    default: n.l_cmd = DDRP_NOP;
                endcase
                n.is_wr = (s.cmd_r[2:0] == DDRP_WR);
            end
        end
        // =====================================================
        // burst engine, one step per half period
        if (tog && s.eng) begin
            n.h = s.h + 7'h1;
            n.dqs_oe = 1'b0;
            n.dq_oe = 1'b0;
            if (s.is_wr) begin
                if (n.h >= wl2 - pre2 && n.h <= wl2 + 7'h8) begin
                    n.dqs_oe = 1'b1;
                    n.dqs_o = (n.h >= wl2 && n.h < wl2 + 7'h8) && !k[0];
                    n.dqsn_o = ~n.dqs_o;
                end
                // no inversion lane here
                n.dq_oe = n.h >= wl2 && n.h < wl2 + 7'h8;
                n.dq_o = s.wdata_r;
                if (n.h == wl2 + 7'h9) begin
                    n.eng = 1'b0;
                    // turnaround plus one, never 5 apart
                    n.gap = 7'(TWTR_NCK) + (s.wr2t ? 7'h1 : 7'h0);
                end
            end else begin
                if (n.h > 7'(2 * RL) && n.h <= 7'(2 * RL + 8))
                    n.rbyte[3'(n.h - 7'(2 * RL) - 7'h1)] = s.dq_s[1];
                if (n.h == 7'(2 * RL + 9)) n.eng = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign link.ck = s.ck;
    assign link.cmd = s.l_cmd;
    assign link.bg = s.l_bank[2];
    assign link.ba = s.l_bank[1:0];
    assign link.addr = s.l_addr;
    assign link.dq_c_o = s.dq_o;
    assign link.dq_c_oe = s.dq_oe;
    assign link.dqs_c_o = s.dqs_o;
    assign link.dqsn_c_o = s.dqsn_o;
    assign link.dqs_c_oe = s.dqs_oe;
endmodule : ddrp_ctl
`default_nettype wire

// >>> logic/ddrp_dev.sv
// ddrp_dev: device end; pattern store, preamble modes, training, banks.
// assumes: link pins are asynchronous to aclk; link clock is slow
// enough that every half period spans several aclk cycles.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - pattern-mode write stores address byte, page 0
// - controller never uses bus inversion then
// - stored patterns persist until reset
// - controller enters mode, page 00 only
// - bank address picks location; rest ignored
// - address bits map onto burst intervals
// - controller waits recovery and exit delay
// - clearing enable exits mode after delay
// - only 1x refresh in pattern mode
// - mode bit selects write preamble length
// - two-clock preamble only on fast grades
// - two-clock write raises latency by two
// - longer turnaround with 2t; pattern write recovery unchanged
// - writes never five clocks apart in 2t
// - mode bit selects read preamble length
// - training bit, allowed only in pattern mode
// - training drives strobes, data held high
// - strobes parked until pattern read, then burst
// - postamble fixed at half a clock
// - activate opens row until precharge
// - precharge idles bank after precharge time
// - auto-precharge deferred past row time, write data
module ddrp_dev #(
    parameter int RL = ddrp_pkg::CL_NCK,
    parameter int WL = ddrp_pkg::WL_NCK,
    parameter bit WL_SET1 = 1'b1,
    parameter int TMOD = ddrp_pkg::TMOD_NCK,
    parameter int TRP = ddrp_pkg::TRP_NCK,
    parameter int TRAS = ddrp_pkg::TRAS_NCK
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    ddrp_link_if.dev link,
    // mode and state view
    output logic pattern_mode,
    output logic train_mode,
    output logic rd_preamble_2t,
    output logic wr_preamble_2t,
    output logic [7:0] bank_open,
    output logic wr_preamble_err
);
    import ddrp_pkg::*;
    localparam int PW = $clog2(TRP + 1);
    localparam int RW = $clog2(TRAS + 1);
    localparam int MW = $clog2(TMOD + 1);
    localparam logic [6:0] RL2 = 7'(2 * RL);

    typedef struct packed {
        logic [1:0] ck_s;
        logic ck_p;
        logic [20:0] c1, c2;
        logic [1:0] dqs_s;
        logic mpr_en;
        logic [1:0] page;
        logic train, rd2t, wr2t;
        logic [3:0][7:0] pat;
        logic [7:0] open, ap;
        logic [7:0][PW-1:0] pre_cnt;
        logic [7:0][RW-1:0] ras_cnt;
        logic rd_act, rd_mpr;
        logic [6:0] rd_h;
        logic [1:0] rd_loc;
        logic wr_act, pre_err;
        logic [6:0] wr_h;
        logic [2:0] wr_bank;
        logic [MW-1:0] sdo_cnt;
        logic train_drv;
        logic [7:0] dq_o;
        logic dq_oe, dqs_o, dqsn_o, dqs_oe;
    } ddrp_dev_st_t;
    ddrp_dev_st_t s, n;

    logic rise, half;
    ddrp_cmd_t cc;
    logic [2:0] bank;
    logic [1:0] cba;
    logic [14:0] ca;
    logic [6:0] wl2, wpre2, rpre2, k;
    assign rise = s.ck_s[1] & ~s.ck_p;
    assign half = s.ck_s[1] ^ s.ck_p;
    assign cc = ddrp_cmd_t'(s.c2[20:18]);
    assign bank = s.c2[17:15];
    assign cba = s.c2[16:15];
    assign ca = s.c2[14:0];
    // latency follows the preamble choice
    assign wl2 = 7'(2 * WL) + ((s.wr2t && WL_SET1) ? 7'h4 : 7'h0);
    assign wpre2 = s.wr2t ? 7'h4 : 7'h2;
    assign rpre2 = s.rd2t ? 7'h4 : 7'h2;
    assign k = n.rd_h - RL2;

    always_comb begin
        n = s;
        // =====================================================
        // pin synchronisers
        n.ck_s = {s.ck_s[0], link.ck};
        n.ck_p = s.ck_s[1];
        n.c1 = {link.cmd, link.bg, link.ba, link.addr};
        n.c2 = s.c1;
        n.dqs_s = {s.dqs_s[0], link.dqs};
        // =====================================================
        // bank timers and deferred auto-precharge
        if (rise) begin
            for (int b = 0; b < 8; b++) begin
                if (s.pre_cnt[b] != '0) n.pre_cnt[b] = s.pre_cnt[b] - 1'b1;
                if (s.ras_cnt[b] != '0) n.ras_cnt[b] = s.ras_cnt[b] - 1'b1;
                if (s.ap[b] && s.ras_cnt[b] == '0 &&
                    !(s.wr_act && s.wr_bank == 3'(b))) begin
                    n.ap[b] = 1'b0;
                    n.open[b] = 1'b0;
                    n.pre_cnt[b] = PW'(TRP);
                end
            end
            if (s.sdo_cnt != '0) begin
                n.sdo_cnt = s.sdo_cnt - 1'b1;
                // drive-out at tmod, inside 9 ns margin
                if (s.sdo_cnt == MW'(1)) n.train_drv = s.train;
            end
        end
        // =====================================================
        // burst positions, counted in link half periods
        if (half && s.rd_act) n.rd_h = s.rd_h + 7'h1;
        if (half && s.wr_act) n.wr_h = s.wr_h + 7'h1;
        if (n.rd_act && n.rd_h == RL2 + 7'h9) n.rd_act = 1'b0;
        if (half && s.wr_act && n.wr_h >= wl2 - wpre2 && n.wr_h < wl2 &&
            s.dqs_s[1]) n.pre_err = 1'b1;
        if (n.wr_act && n.wr_h == wl2 + 7'h9) n.wr_act = 1'b0;
        // =====================================================
        // command decode on the sampled rising edge
        if (rise) begin
            unique case (cc)
                DDRP_MRS: begin
                    if (bank == MR_PATTERN) begin
                        n.mpr_en = ca[MR3_EN_BIT];
                        n.page = ca[1:0];
                    end
                    if (bank == MR_PREAMBLE) begin
                        n.wr2t = ca[MR4_WRPRE_BIT];
                        n.rd2t = ca[MR4_RDPRE_BIT];
                        n.train = ca[MR4_TRAIN_BIT] & s.mpr_en;
                        if (n.train && !s.train) n.sdo_cnt = MW'(TMOD);
                        if (!n.train) begin
                            n.train_drv = 1'b0;
                            n.sdo_cnt = '0;
                        end
                    end
                end
                DDRP_ACT: begin
                    if (!s.open[bank] && n.pre_cnt[bank] == '0) begin
                        n.open[bank] = 1'b1;
                        n.ras_cnt[bank] = RW'(TRAS);
                    end
                end
                DDRP_PRE: begin
                    for (int b = 0; b < 8; b++) begin
                        if (ca[AP_BIT] || bank == 3'(b)) begin
                            // a repeat restarts the period
                            n.open[b] = 1'b0;
                            n.ap[b] = 1'b0;
                            n.pre_cnt[b] = PW'(TRP);
                        end
                    end
                end
                DDRP_RD: begin
                    n.rd_act = 1'b1;
                    n.rd_h = 7'h0;
                    n.rd_loc = cba;
                    n.rd_mpr = s.mpr_en;
                    if (!s.mpr_en && ca[AP_BIT] && s.open[bank])
                        n.ap[bank] = 1'b1;
                end
                DDRP_WR: begin
                    if (s.mpr_en) begin
                        // a10 and group ignored here
                        if (s.page == 2'h0)
                            n.pat[cba] = ca[7:0];
                    end else begin
                        n.wr_act = 1'b1;
                        n.wr_h = 7'h0;
                        n.wr_bank = bank;
                        if (ca[AP_BIT] && s.open[bank])
                            n.ap[bank] = 1'b1;
                    end
                end
                DDRP_NOP, DDRP_REF: ;
                default: ;
            endcase
        end
        // =====================================================
        // strobe and data drive
        n.dq_oe = 1'b0;
        n.dqs_oe = 1'b0;
        n.dqs_o = 1'b0;
        n.dqsn_o = 1'b1;
        n.dq_o = 8'hff;
        if (n.train_drv) begin
            n.dqs_oe = 1'b1; // parked low/high
            n.dq_oe = 1'b1;
        end
        if (n.rd_act && n.rd_h >= RL2 - rpre2) begin
            n.dqs_oe = 1'b1;
            if (n.rd_h >= RL2 && n.rd_h < RL2 + 7'h8) begin
                // toggle after latency, serial pattern
                n.dqs_o = ~k[0];
                n.dqsn_o = k[0];
                n.dq_oe = 1'b1;
                n.dq_o = {8{s.rd_mpr & s.pat[s.rd_loc][k[2:0]]}};
            end
            // half-clock postamble in either mode
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0; // patterns clear only here
            s.dqsn_o <= 1'b1;
            s.dq_o <= 8'hff;
        end else begin
            s <= n;
        end
    end

    assign pattern_mode = s.mpr_en;
    assign train_mode = s.train;
    assign rd_preamble_2t = s.rd2t;
    assign wr_preamble_2t = s.wr2t;
    assign bank_open = s.open;
    assign wr_preamble_err = s.pre_err;
    assign link.dq_d_o = s.dq_o;
    assign link.dq_d_oe = s.dq_oe;
    assign link.dqs_d_o = s.dqs_o;
    assign link.dqsn_d_o = s.dqsn_o;
    assign link.dqs_d_oe = s.dqs_oe;
endmodule : ddrp_dev
`default_nettype wire

// >>> dv/ddrp_link_chk.sv
// ddrp_link_chk: link and mode-flag checks, aclk domain.
// assumes: sits beside the link interface in the bench.
`timescale 1ns/1ps
`default_nettype none
module ddrp_link_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link and device view
    input wire ddrp_pkg::ddrp_cmd_t cmd,
    input wire logic bg,
    input wire logic [1:0] ba,
    input wire logic [14:0] addr,
    input wire logic [7:0] dq_d_o,
    input wire logic dq_d_oe,
    input wire logic dqs_d_o,
    input wire logic dqs_d_oe,
    input wire logic pattern_mode,
    input wire logic train_mode,
    input wire logic rd_preamble_2t,
    input wire logic wr_preamble_2t,
    input wire logic [7:0] bank_open
);
    import ddrp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // mode flags
    chk_train_in_pat: assert property (train_mode |-> pattern_mode)
        else $error("train outside pattern");
    chk_train_drive: assert property ($rose(train_mode) |-> ##[0:200]
        (dqs_d_oe && !dqs_d_o && dq_d_oe && dq_d_o == 8'hff))
        else $error("train park late");
    chk_wrpre_set: assert property ($rose(wr_preamble_2t) |->
        cmd == DDRP_MRS && {bg, ba} == MR_PREAMBLE && addr[MR4_WRPRE_BIT])
        else $error("stray wr preamble set");
    chk_rdpre_set: assert property ($rose(rd_preamble_2t) |->
        cmd == DDRP_MRS && {bg, ba} == MR_PREAMBLE && addr[MR4_RDPRE_BIT])
        else $error("stray rd preamble set");
    chk_pat_enter: assert property ($rose(pattern_mode) |->
        cmd == DDRP_MRS && {bg, ba} == MR_PATTERN && addr[MR3_EN_BIT])
        else $error("stray pattern entry");
    chk_pat_exit: assert property ($fell(pattern_mode) |->
        cmd == DDRP_MRS && {bg, ba} == MR_PATTERN && !addr[MR3_EN_BIT])
        else $error("stray pattern exit");
    // ==========================================================
    // banks and strobes
    chk_act_opens: assert property ((bank_open & ~$past(bank_open)) != 0 |->
        cmd == DDRP_ACT &&
        (bank_open & ~$past(bank_open)) == (8'h01 << {bg, ba}))
        else $error("stray bank open");
    chk_postamble: assert property ($fell(dqs_d_oe) |->
        $past(dqs_d_o, 8) == 1'b0)
        else $error("bad postamble");
    cov_train: cover property ($rose(train_mode));
    cov_exit: cover property ($fell(pattern_mode));
    cov_close: cover property ($fell(|bank_open));
endmodule : ddrp_link_chk
`default_nettype wire

// >>> dv/tb_ddr4_pattern_preamble_bank_ops.sv
// tb: register-level scenarios, controller against device.
// assumes: both ends joined by one link interface; aclk 125 MHz.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr4_pattern_preamble_bank_ops;
    import ddrp_pkg::*;
    logic aclk, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, bank_open;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic pattern_mode, train_mode, rd2t, wr2t, wr_err;
    int fails = 0, n_checks = 0;
    ddrp_link_if lk();
    ddrp_ctl ddrp_ctl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link(lk));
    ddrp_dev #(.TMOD(4)) ddrp_dev_i (.aclk(aclk), .aresetn(aresetn),
        .link(lk), .pattern_mode(pattern_mode), .train_mode(train_mode),
        .rd_preamble_2t(rd2t), .wr_preamble_2t(wr2t),
        .bank_open(bank_open), .wr_preamble_err(wr_err));
    ddrp_link_chk ddrp_link_chk_i (.aclk(aclk), .aresetn(aresetn),
        .cmd(lk.cmd), .bg(lk.bg), .ba(lk.ba), .addr(lk.addr),
        .dq_d_o(lk.dq_d_o), .dq_d_oe(lk.dq_d_oe), .dqs_d_o(lk.dqs_d_o),
        .dqs_d_oe(lk.dqs_d_oe), .pattern_mode(pattern_mode),
        .train_mode(train_mode), .rd_preamble_2t(rd2t),
        .wr_preamble_2t(wr2t), .bank_open(bank_open));
    // ==========================================================
    // bus tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        st = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr
    // one command, then poll until idle
    task automatic issue(input ddrp_cmd_t c, input logic [2:0] s,
                         input logic [14:0] a);
        axw(REG_ADDR, {17'h0, a});
        axw(REG_CMD, {26'h0, s, c});
        do axr(REG_STATUS); while (st[0] !== 1'b0);
    endtask : issue
    // ==========================================================
    // scenarios
    task automatic t_regs();
        axr(REG_STATUS);
        chk("status reset", st, 32'h0);
        axr(8'h10);
        chk("rd unmapped", {r, st[29:0]}, {RESP_SLVERR, 30'h0});
        axw(8'h10, 32'h0);
        chk("wr unmapped", r, RESP_SLVERR);
    endtask : t_regs
    task automatic t_pattern();
        issue(DDRP_MRS, MR_PATTERN, 15'h0004);
        chk("pat on", {pattern_mode, st[1]}, 2'b11);
        issue(DDRP_WR, 3'h6, 15'h04a5);
        issue(DDRP_WR, 3'h0, 15'h003c);
        chk("no bank", bank_open, 8'h00);
        issue(DDRP_REF, 3'h0, 15'h0000);
        issue(DDRP_RD, 3'h2, 15'h0000);
        chk("loc2", st[15:8], 8'ha5);
        issue(DDRP_RD, 3'h0, 15'h0000);
        chk("loc0", st[15:8], 8'h3c);
    endtask : t_pattern
    task automatic t_train();
        issue(DDRP_MRS, MR_PREAMBLE, 15'h0400);
        chk("train on", train_mode, 1'b1);
        chk("park", {lk.dqs, lk.dqs_n, lk.dq}, 10'h1ff);
        issue(DDRP_RD, 3'h2, 15'h0000);
        chk("train rd", {st[15:8], lk.dqs}, 9'h14a);
        issue(DDRP_MRS, MR_PREAMBLE, 15'h0000);
        issue(DDRP_MRS, MR_PATTERN, 15'h0000);
        chk("pat off", {pattern_mode, train_mode}, 2'b00);
        issue(DDRP_MRS, MR_PREAMBLE, 15'h0400);
        chk("train blocked", train_mode, 1'b0);
    endtask : t_train
    task automatic t_banks();
        issue(DDRP_MRS, MR_PREAMBLE, 15'h1800);
        chk("2t", {wr2t, rd2t, st[2]}, 3'b111);
        issue(DDRP_ACT, 3'h6, 15'h1234);
        chk("act", bank_open, 8'h40);
        axw(REG_WDATA, 32'h5a);
        issue(DDRP_WR, 3'h6, 15'h0000);
        chk("wr pre", wr_err, 1'b0);
        issue(DDRP_RD, 3'h6, 15'h0400);
        repeat (TRAS_NCK * 2 * CK_HALF) @(posedge aclk);
        chk("autopre", bank_open, 8'h00);
        issue(DDRP_PRE, 3'h6, 15'h0000);
        issue(DDRP_ACT, 3'h1, 15'h0000);
        chk("reopen", bank_open, 8'h02);
        issue(DDRP_PRE, 3'h1, 15'h0000);
        chk("pre", bank_open, 8'h00);
    endtask : t_banks
    task automatic t_persist();
        issue(DDRP_MRS, MR_PATTERN, 15'h0004);
        issue(DDRP_RD, 3'h2, 15'h0000);
        chk("kept", st[15:8], 8'ha5);
    endtask : t_persist
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        repeat (60000) @(posedge aclk);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_pattern();
        t_train();
        t_banks();
        t_persist();
        wrap_up();
    end
endmodule : tb_ddr4_pattern_preamble_bank_ops
`default_nettype wire
